// File: logic/dio_consts.svh
// Register offsets, field positions, reset values and timing counts
`ifndef DIO_CONSTS_SVH
`define DIO_CONSTS_SVH

// Timebase
`define DIO_CLK_PERIOD_NS 10
`define DIO_TICK_PERIOD_NS 1000000
`define DIO_TICK_CYCLES (`DIO_TICK_PERIOD_NS / `DIO_CLK_PERIOD_NS)

// Register offsets (byte addresses)
`define DIO_STATUS_OFS 12'h000
`define DIO_FNREQ_OFS 12'h004
`define DIO_IN_CFG_BASE 12'h100
`define DIO_OUT_TIME_BASE 12'h200
`define DIO_OUT_FN_BASE 12'h208

// Input configuration fields
`define DIO_IN_DLY_LSB 0
`define DIO_IN_LO_LSB 8
`define DIO_IN_HI_LSB 12

// Output timing fields
`define DIO_OUT_ACT_LSB 0
`define DIO_OUT_HOLD_LSB 16
`define DIO_OUT_POL_BIT 30

// Status fields
`define DIO_ST_DI_LSB 0
`define DIO_ST_DQ_LSB 12
`define DIO_ST_PRESENT_BIT 16

// Setting limits and reset values, in ms
`define DIO_IN_DLY_MAX 8'd200
`define DIO_OUT_ACT_MAX 16'd60000
`define DIO_OUT_HOLD_MAX 14'd9999
`define DIO_IN_DLY_RST 8'h00
`define DIO_OUT_ACT_RST 16'h0000
`define DIO_OUT_HOLD_RST 14'h0000
`define DIO_OUT_POL_RST 1'b0

`endif

// File: logic/dio_pkg.sv
// Types shared by the digital I/O conditioning block
`default_nettype none
package dio_pkg;
    // Function codes; info_src bit index equals the code
    typedef enum logic [3:0] {
        DIO_FN_NONE  = 4'h0,
        DIO_FN_FAULT = 4'h1,
        DIO_FN_MAINS = 4'h2,
        DIO_FN_BRAKE = 4'h3
    } dio_fn_t;
    typedef logic [7:0] dio_in_dly_t;
    typedef logic [15:0] dio_act_dly_t;
    typedef logic [13:0] dio_hold_dly_t;
endpackage
`default_nettype wire

// File: logic/dio_ms_tick.sv
// Millisecond tick generator
`default_nettype none
module dio_ms_tick
    import dio_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = 100000
) (
    input wire logic clk,
    input wire logic rstn,
    output logic tick
);
    logic [16:0] cnt_r;
    logic [16:0] cnt_nxt;
    logic tick_r;
    logic tick_nxt;

    always_comb begin
        cnt_nxt = cnt_r + 17'h00001;
        tick_nxt = 1'b0;
        if (cnt_r == 17'(TICK_CYCLES - 1)) begin
            cnt_nxt = 17'h00000;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt_r <= 17'h00000;
            tick_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick = tick_r;
endmodule // dio_ms_tick
`default_nettype wire

// File: logic/dio_delay_chan.sv
// One delayed level channel with separate rise and fall delays
`default_nettype none
module dio_delay_chan
    import dio_pkg::*;
#(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic tick,
    input wire logic raw,
    input wire logic [W-1:0] rise_dly,
    input wire logic [W-1:0] fall_dly,
    output logic state
);
    logic state_r;
    logic state_nxt;
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    logic [W-1:0] dly;

    always_comb begin
        dly = raw ? rise_dly : fall_dly;
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        if (raw == state_r) begin
            cnt_nxt = '0;
        end else if (cnt_r >= dly) begin
            state_nxt = raw;
            cnt_nxt = '0;
        end else if (tick) begin
            cnt_nxt = cnt_r + W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_r <= 1'b0;
            cnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign state = state_r;

    property p_restart;
        @(posedge clk) disable iff (!rstn)
        (raw == state_r) |=> (cnt_r == '0);
    endproperty
    a_restart: assert property (p_restart)
        else $error("Delay count not restarted");
endmodule // dio_delay_chan
`default_nettype wire

// File: logic/dio_top.sv
// Digital input and output delay and polarity conditioning, APB slave
// Functional notes
// - Each input's level is acted on only after its delay of 0 to 200 ms.
// - Every input has a low-level function, a high-level function, a delay.
// - Extension inputs and outputs are settable only with the module present.
// - An output turns on only after its activation delay of 0 to 60000 ms.
// - Fault and mains contactor outputs use a zero, fixed activation delay.
// - Each output has a polarity: default 1 when true, else 0 when true.
// - Fault, brake and mains contactor outputs are locked to active high.
// - An output turns off only after its hold delay of 0 to 9999 ms.
// - Fault, brake and mains contactor outputs use a zero, fixed hold delay.
// - The second extension output behaves exactly like the first.
`include "dio_consts.svh"
`default_nettype none
module dio_top
    import dio_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `DIO_TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [5:0] base_di_pin,
    input wire logic [5:0] ext_di_pin,
    input wire logic ext_module_present,
    input wire logic [15:0] info_src,
    output logic [15:0] fn_req,
    output logic ext_digital_output_first,
    output logic ext_digital_output_second
);
    localparam int NIN = 12;
    localparam int NBASE = 6;

    logic tick;
    logic [NIN-1:0] in_raw;
    logic [NIN-1:0] in_state;
    logic [1:0] out_raw;
    logic [1:0] out_state;

    dio_in_dly_t in_dly_r [NIN];
    dio_in_dly_t in_dly_nxt [NIN];
    dio_fn_t in_lo_r [NIN];
    dio_fn_t in_lo_nxt [NIN];
    dio_fn_t in_hi_r [NIN];
    dio_fn_t in_hi_nxt [NIN];
    dio_act_dly_t out_act_r [2];
    dio_act_dly_t out_act_nxt [2];
    dio_hold_dly_t out_hold_r [2];
    dio_hold_dly_t out_hold_nxt [2];
    logic [1:0] out_pol_r;
    logic [1:0] out_pol_nxt;
    dio_fn_t out_fn_r [2];
    dio_fn_t out_fn_nxt [2];

    dio_act_dly_t act_eff [2];
    dio_hold_dly_t hold_eff [2];
    logic [1:0] pol_eff;
    logic [1:0] lock_act;
    logic [1:0] lock_all;

    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic [15:0] fn_req_r;
    logic [15:0] fn_req_nxt;
    logic [1:0] dq_pin_r;
    logic [1:0] dq_pin_nxt;

    logic hit_status;
    logic hit_fnreq;
    logic hit_in;
    logic hit_out;
    logic addr_ok;
    logic blocked;
    logic [3:0] in_idx;
    logic out_idx;
    logic [31:0] rd_val;
    logic wr_en;

    dio_ms_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk(clk),
        .rstn(rstn),
        .tick(tick)
    );

    // Extension inputs read as low while the module is absent
    assign in_raw = {ext_di_pin & {NBASE{ext_module_present}}, base_di_pin};

    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi++) begin : g_in
            dio_delay_chan #(
                .W(8)
            ) u_in (
                .clk(clk),
                .rstn(rstn),
                .tick(tick),
                .raw(in_raw[gi]),
                .rise_dly(in_dly_r[gi]),
                .fall_dly(in_dly_r[gi]),
                .state(in_state[gi])
            );
        end
        for (gi = 0; gi < 2; gi++) begin : g_out
            // Forced functions lose hold delay and polarity; fault and mains also lose the activation delay
            assign lock_act[gi] = (out_fn_r[gi] == DIO_FN_FAULT) ||
                (out_fn_r[gi] == DIO_FN_MAINS);
            assign lock_all[gi] = lock_act[gi] ||
                (out_fn_r[gi] == DIO_FN_BRAKE);
            assign act_eff[gi] = lock_act[gi] ? '0 : out_act_r[gi];
            assign hold_eff[gi] = lock_all[gi] ? '0 : out_hold_r[gi];
            assign pol_eff[gi] = lock_all[gi] ? 1'b0 : out_pol_r[gi];
            assign out_raw[gi] = ext_module_present &&
                (out_fn_r[gi] != DIO_FN_NONE) && info_src[out_fn_r[gi]];
            dio_delay_chan #(
                .W(16)
            ) u_out (
                .clk(clk),
                .rstn(rstn),
                .tick(tick),
                .raw(out_raw[gi]),
                .rise_dly(act_eff[gi]),
                .fall_dly({2'b00, hold_eff[gi]}),
                .state(out_state[gi])
            );
        end
    endgenerate

    // Address decode
    always_comb begin
        hit_status = (paddr == `DIO_STATUS_OFS);
        hit_fnreq = (paddr == `DIO_FNREQ_OFS);
        in_idx = paddr[5:2];
        out_idx = paddr[2];
        hit_in = (paddr[11:8] == `DIO_IN_CFG_BASE >> 8) &&
            (paddr[7:6] == 2'b00) && (paddr[1:0] == 2'b00) &&
            (in_idx < 4'(NIN));
        hit_out = (paddr[11:4] == `DIO_OUT_TIME_BASE >> 4) &&
            (paddr[1:0] == 2'b00);
        addr_ok = hit_status || hit_fnreq || hit_in || hit_out;
        // Extension settings vanish while the module is absent
        blocked = !ext_module_present &&
            (hit_out || (hit_in && in_idx >= 4'(NBASE)));
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign wr_en = psel && penable && pwrite && addr_ok && !blocked;

    // Read mux
    always_comb begin
        rd_val = 32'h00000000;
        if (blocked) begin
            rd_val = 32'h00000000;
        end else if (hit_status) begin
            rd_val[`DIO_ST_DI_LSB +: NIN] = in_state;
            rd_val[`DIO_ST_DQ_LSB +: 2] = dq_pin_r;
            rd_val[`DIO_ST_PRESENT_BIT] = ext_module_present;
        end else if (hit_fnreq) begin
            rd_val[15:0] = fn_req_r;
        end else if (hit_in) begin
            rd_val[`DIO_IN_DLY_LSB +: 8] = in_dly_r[in_idx];
            rd_val[`DIO_IN_LO_LSB +: 4] = in_lo_r[in_idx];
            rd_val[`DIO_IN_HI_LSB +: 4] = in_hi_r[in_idx];
        end else if (hit_out && !paddr[3]) begin
            rd_val[`DIO_OUT_ACT_LSB +: 16] = act_eff[out_idx];
            rd_val[`DIO_OUT_HOLD_LSB +: 14] = hold_eff[out_idx];
            rd_val[`DIO_OUT_POL_BIT] = pol_eff[out_idx];
        end else if (hit_out) begin
            rd_val[3:0] = out_fn_r[out_idx];
        end
    end

    // Register file next state
    always_comb begin
        in_dly_nxt = in_dly_r;
        in_lo_nxt = in_lo_r;
        in_hi_nxt = in_hi_r;
        out_act_nxt = out_act_r;
        out_hold_nxt = out_hold_r;
        out_pol_nxt = out_pol_r;
        out_fn_nxt = out_fn_r;
        prdata_nxt = prdata_r;
        // Data sampled in setup so it is stable through the access phase
        if (psel && !penable) begin
            prdata_nxt = rd_val;
        end
        if (wr_en && hit_in) begin
            // Out of range settings saturate at the limit
            if (pwdata[`DIO_IN_DLY_LSB +: 8] > `DIO_IN_DLY_MAX) begin
                in_dly_nxt[in_idx] = `DIO_IN_DLY_MAX;
            end else begin
                in_dly_nxt[in_idx] = pwdata[`DIO_IN_DLY_LSB +: 8];
            end
            in_lo_nxt[in_idx] = dio_fn_t'(pwdata[`DIO_IN_LO_LSB +: 4]);
            in_hi_nxt[in_idx] = dio_fn_t'(pwdata[`DIO_IN_HI_LSB +: 4]);
        end
        if (wr_en && hit_out && !paddr[3]) begin
            if (!lock_act[out_idx]) begin
                if (pwdata[`DIO_OUT_ACT_LSB +: 16] > `DIO_OUT_ACT_MAX) begin
                    out_act_nxt[out_idx] = `DIO_OUT_ACT_MAX;
                end else begin
                    out_act_nxt[out_idx] = pwdata[`DIO_OUT_ACT_LSB +: 16];
                end
            end
            if (!lock_all[out_idx]) begin
                if (pwdata[`DIO_OUT_HOLD_LSB +: 14] > `DIO_OUT_HOLD_MAX) begin
                    out_hold_nxt[out_idx] = `DIO_OUT_HOLD_MAX;
                end else begin
                    out_hold_nxt[out_idx] = pwdata[`DIO_OUT_HOLD_LSB +: 14];
                end
                out_pol_nxt[out_idx] = pwdata[`DIO_OUT_POL_BIT];
            end
        end
        if (wr_en && hit_out && paddr[3]) begin
            out_fn_nxt[out_idx] = dio_fn_t'(pwdata[3:0]);
            // Locked settings drop to their fixed values
            if (pwdata[3:0] == DIO_FN_FAULT ||
                    pwdata[3:0] == DIO_FN_MAINS) begin
                out_act_nxt[out_idx] = '0;
            end
            if (pwdata[3:0] != 4'h0 && pwdata[3:0] <= DIO_FN_BRAKE) begin
                out_hold_nxt[out_idx] = '0;
                out_pol_nxt[out_idx] = 1'b0;
            end
        end
    end

    // Function requests and output pins
    always_comb begin
        fn_req_nxt = 16'h0000;
        for (int i = 0; i < NIN; i++) begin
            if (i < NBASE || ext_module_present) begin
                if (in_state[i] && in_hi_r[i] != DIO_FN_NONE) begin
                    fn_req_nxt[in_hi_r[i]] = 1'b1;
                end
                if (!in_state[i] && in_lo_r[i] != DIO_FN_NONE) begin
                    fn_req_nxt[in_lo_r[i]] = 1'b1;
                end
            end
        end
        for (int j = 0; j < 2; j++) begin
            // Absent module: pins parked low whatever the polarity
            dq_pin_nxt[j] = ext_module_present &&
                (out_state[j] ^ pol_eff[j]);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            for (int i = 0; i < NIN; i++) begin
                in_dly_r[i] <= `DIO_IN_DLY_RST;
                in_lo_r[i] <= DIO_FN_NONE;
                in_hi_r[i] <= DIO_FN_NONE;
            end
            for (int j = 0; j < 2; j++) begin
                out_act_r[j] <= `DIO_OUT_ACT_RST;
                out_hold_r[j] <= `DIO_OUT_HOLD_RST;
                out_fn_r[j] <= DIO_FN_NONE;
            end
            out_pol_r <= {2{`DIO_OUT_POL_RST}};
            prdata_r <= 32'h00000000;
            fn_req_r <= 16'h0000;
            dq_pin_r <= 2'b00;
        end else begin
            in_dly_r <= in_dly_nxt;
            in_lo_r <= in_lo_nxt;
            in_hi_r <= in_hi_nxt;
            out_act_r <= out_act_nxt;
            out_hold_r <= out_hold_nxt;
            out_pol_r <= out_pol_nxt;
            out_fn_r <= out_fn_nxt;
            prdata_r <= prdata_nxt;
            fn_req_r <= fn_req_nxt;
            dq_pin_r <= dq_pin_nxt;
        end
    end

    assign prdata = prdata_r;
    assign fn_req = fn_req_r;
    assign ext_digital_output_first = dq_pin_r[0];
    assign ext_digital_output_second = dq_pin_r[1];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence s_in0_change;
        (in_dly_r[0] == 8'h00) && (in_raw[0] != in_state[0]);
    endsequence

    property p_in_zero;
        s_in0_change |=> (in_state[0] == $past(in_raw[0]));
    endproperty
    a_in_zero: assert property (p_in_zero)
        else $error("Zero input delay not applied next cycle");

    property p_in_follow;
        $changed(in_state[0]) |-> (in_state[0] == $past(in_raw[0]));
    endproperty
    a_in_follow: assert property (p_in_follow)
        else $error("Input state changed to a level not present");

    property p_in_range;
        in_dly_r[3] <= `DIO_IN_DLY_MAX;
    endproperty
    a_in_range: assert property (p_in_range)
        else $error("Input delay beyond 200 ms");

    property p_out_range;
        (out_act_r[0] <= `DIO_OUT_ACT_MAX) &&
        (out_hold_r[1] <= `DIO_OUT_HOLD_MAX);
    endproperty
    a_out_range: assert property (p_out_range)
        else $error("Output delay beyond its limit");

    sequence s_locked_rise(int j);
        lock_act[j] && out_raw[j] && !out_state[j];
    endsequence

    property p_act_lock;
        s_locked_rise(0) |=> out_state[0] ##1 ext_digital_output_first;
    endproperty
    a_act_lock: assert property (p_act_lock)
        else $error("Locked output did not turn on at once");

    property p_hold_lock;
        lock_all[1] && !out_raw[1] && out_state[1] |=>
            !out_state[1] ##1 !ext_digital_output_second;
    endproperty
    a_hold_lock: assert property (p_hold_lock)
        else $error("Locked output did not turn off at once");

    property p_pol_lock;
        lock_all[0] && ext_module_present && $stable(ext_module_present) |=>
            (ext_digital_output_first == $past(out_state[0]));
    endproperty
    a_pol_lock: assert property (p_pol_lock)
        else $error("Locked output not active high");

    property p_pol_inv;
        !lock_all[1] && out_pol_r[1] && ext_module_present |=>
            (ext_digital_output_second == !$past(out_state[1]));
    endproperty
    a_pol_inv: assert property (p_pol_inv)
        else $error("Inverted polarity not applied");

    property p_absent;
        !ext_module_present |=> !in_state[NBASE] ##0
            !ext_digital_output_first ##0 !ext_digital_output_second;
    endproperty
    a_absent: assert property (p_absent)
        else $error("Extension I/O active without the module");

    property p_fn_high;
        in_state[2] && in_hi_r[2] != DIO_FN_NONE |=>
            fn_req[$past(in_hi_r[2])];
    endproperty
    a_fn_high: assert property (p_fn_high)
        else $error("High-level function not requested");
endmodule // dio_top
`default_nettype wire

// File: dv/dio_field_model.sv
// Field wiring model: switches feeding the digital inputs
`default_nettype none
module dio_field_model (
    input wire logic clk,
    input wire logic present,
    input wire logic [11:0] sw,
    output logic [5:0] base_di_pin,
    output logic [5:0] ext_di_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        base_di_pin = 6'h00;
        ext_di_pin = 6'h00;
    end
    // Unplugged extension lines float, so show a changing pattern
    always @(posedge clk) begin
        base_di_pin <= sw[5:0];
        ext_di_pin <= present ? sw[11:6] : ~ext_di_pin;
    end
endmodule // dio_field_model
`default_nettype wire

// File: dv/dio_top_tb.sv
// Self-checking bench for the digital I/O conditioning block
`include "dio_consts.svh"
`default_nettype none
`define CHK(nm, e, g) begin \
    num_checks++; \
    if ((g) !== (e)) begin \
        n_errors++; \
        $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
    end \
end
module dio_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TK = 10;
    localparam logic [11:0] ST = `DIO_STATUS_OFS;
    localparam logic [11:0] FQ = `DIO_FNREQ_OFS;
    typedef struct packed {
        logic [31:0] d;
        logic [31:0] m;
        logic e;
    } dio_exp_t;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, out_first, out_second;
    logic present = 1'b1;
    logic [11:0] sw = 12'h000;
    logic [15:0] info_src = 16'h0000;
    logic [15:0] fn_req;
    logic [5:0] base_di_pin, ext_di_pin;
    int n_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    int seed = 55;
    dio_exp_t exp_q[$];
    dio_exp_t x;
    logic [31:0] pin_word;

    // Output pins placed where the status word shows them
    assign pin_word = {18'h0, out_second, out_first, 12'h0};

    always #5 clk = ~clk;

    dio_top #(.TICK_CYCLES(TK)) i_dut (
        .clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .base_di_pin(base_di_pin), .ext_di_pin(ext_di_pin),
        .ext_module_present(present), .info_src(info_src),
        .fn_req(fn_req), .ext_digital_output_first(out_first),
        .ext_digital_output_second(out_second)
    );

    dio_field_model i_field (
        .clk(clk), .present(present), .sw(sw),
        .base_di_pin(base_di_pin), .ext_di_pin(ext_di_pin)
    );

    task automatic final_report();
        if (n_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            final_report();
        end
    end

    // Completed transfers are matched against the oldest note
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1) begin
            if (exp_q.size() == 0) begin
                `CHK("queue", 1'b1, 1'b0)
            end else begin
                x = exp_q.pop_front();
                `CHK("prdata", x.d & x.m, prdata & x.m)
                `CHK("pslverr", x.e, pslverr)
                if (!pwrite && paddr == FQ) begin
                    `CHK("fn_req", x.d & x.m, {16'h0, fn_req} & x.m)
                end
                if (!pwrite && paddr == ST) begin
                    `CHK("pins", x.d & x.m & 32'h3000, pin_word & x.m)
                end
            end
        end
    end

    task automatic apb(input logic wr, input logic [11:0] a,
            input logic [31:0] d, input logic [31:0] m, input logic e);
        exp_q.push_back({d, m, e});
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wr ? d : 32'h0;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // Only the bench timeout ends a wait for the answer
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] d,
            input logic [31:0] m);
        apb(1'b0, a, d, m, 1'b0);
    endtask

    task automatic ms(input int k);
        repeat (k * TK) @(posedge clk);
    endtask

    function automatic logic [11:0] icfg(input int i);
        return `DIO_IN_CFG_BASE + 12'(4 * i);
    endfunction

    function automatic logic [11:0] otime(input int i);
        return `DIO_OUT_TIME_BASE + 12'(4 * i);
    endfunction

    function automatic logic [11:0] ofn(input int i);
        return `DIO_OUT_FN_BASE + 12'(4 * i);
    endfunction

    initial begin
        int i;
        logic [31:0] r;
        logic [31:0] mk;
        logic [7:0] dl;
        logic [15:0] ac;
        logic [13:0] ho;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        rd(ST, 32'h1 << `DIO_ST_PRESENT_BIT, '1);
        rd(FQ, 32'h0, '1);
        rd(icfg(0), 32'h0, '1);
        rd(otime(1), 32'h0, '1);
        rd(ofn(1), 32'h0, '1);
        apb(1'b0, 12'h300, 32'h0, '1, 1'b1);
        apb(1'b1, 12'h102, 32'h5, 32'h0, 1'b1);
        // Input 0 without delay, input 1 with 5 ms and a low function
        wr(icfg(0), 32'h5000);
        wr(icfg(1), 32'h6705);
        rd(FQ, 32'h80, 32'he0);
        sw <= 12'h003;
        repeat (3) @(posedge clk);
        rd(FQ, 32'ha0, 32'he0);
        ms(3);
        rd(FQ, 32'ha0, 32'he0);
        sw <= 12'h001;
        repeat (3) @(posedge clk);
        sw <= 12'h003;
        ms(3);
        rd(FQ, 32'ha0, 32'he0);
        ms(3);
        rd(FQ, 32'h60, 32'he0);
        // Extension input seen only with the module fitted
        wr(icfg(6), 32'h8900);
        rd(FQ, 32'h200, 32'h300);
        present <= 1'b0;
        repeat (4) @(posedge clk);
        rd(FQ, 32'h0, 32'h300);
        rd(icfg(6), 32'h0, '1);
        wr(icfg(6), 32'h0033);
        wr(otime(0), 32'h5);
        present <= 1'b1;
        repeat (2) @(posedge clk);
        rd(icfg(6), 32'h8900, '1);
        rd(otime(0), 32'h0, '1);
        // Both outputs: activation 2 ms, hold 3 ms, then inverted level
        for (i = 0; i < 2; i++) begin
            mk = 32'h1000 << i;
            wr(ofn(i), 32'(10 + i));
            wr(otime(i), 32'h0003_0002);
            info_src[10 + i] <= 1'b1;
            ms(1);
            rd(ST, 32'h0, mk);
            ms(3);
            rd(ST, mk, mk);
            info_src[10 + i] <= 1'b0;
            ms(2);
            rd(ST, mk, mk);
            ms(3);
            rd(ST, 32'h0, mk);
            wr(otime(i), 32'h4000_0000);
            repeat (3) @(posedge clk);
            rd(ST, mk, mk);
            info_src[10 + i] <= 1'b1;
            repeat (3) @(posedge clk);
            rd(ST, 32'h0, mk);
            info_src[10 + i] <= 1'b0;
        end
        // Fault and mains lock all their timing settings, brake locks only hold and polarity
        for (i = 1; i < 4; i++) begin
            wr(ofn(0), 32'(i));
            wr(otime(0), 32'h4007_0005);
            rd(otime(0), (i == 3) ? 32'h5 : 32'h0, '1);
        end
        wr(ofn(0), 32'h1);
        info_src[1] <= 1'b1;
        repeat (3) @(posedge clk);
        rd(ST, 32'h1000, 32'h1000);
        wr(ofn(0), 32'h0);
        // Brake on the second output: hold and polarity stay locked
        wr(ofn(1), 32'h3);
        wr(otime(1), 32'h4007_0000);
        info_src[3] <= 1'b1;
        repeat (3) @(posedge clk);
        rd(ST, 32'h2000, 32'h2000);
        info_src[3] <= 1'b0;
        repeat (3) @(posedge clk);
        rd(ST, 32'h0, 32'h2000);
        // Range limits, first case just above the input delay and activation limits, hold at its field maximum
        for (i = 0; i < 12; i++) begin
            r = (i == 0) ? 32'h0000_00c9 : $random(seed);
            dl = (r[7:0] > `DIO_IN_DLY_MAX) ? `DIO_IN_DLY_MAX : r[7:0];
            wr(icfg(i), r);
            rd(icfg(i), {16'h0, r[15:8], dl}, 32'hffff);
        end
        for (i = 0; i < 4; i++) begin
            r = (i == 0) ? 32'h3fff_ea61 : $random(seed);
            ac = (r[15:0] > `DIO_OUT_ACT_MAX) ? `DIO_OUT_ACT_MAX : r[15:0];
            ho = (r[29:16] > `DIO_OUT_HOLD_MAX) ? `DIO_OUT_HOLD_MAX
                : r[29:16];
            wr(otime(0), r);
            rd(otime(0), {1'b0, r[30], ho, ac}, 32'h7fff_ffff);
        end
        // High function of a held input, then a reset in mid-run
        wr(icfg(2), 32'hb000);
        sw <= 12'h004;
        repeat (3) @(posedge clk);
        rd(FQ, 32'h800, 32'h800);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rd(otime(0), 32'h0, '1);
        rd(FQ, 32'h0, '1);
        repeat (2) @(posedge clk);
        final_report();
    end
endmodule // dio_top_tb
`default_nettype wire
